// file: fdc_pkg.sv
// Package for the fieldbus drive control and status block
package fdc_pkg;
    // Command word bit positions
    localparam int CW_ON1 = 0;
    localparam int CW_ON2 = 1;
    localparam int CW_ON3 = 2;
    localparam int CW_NOCOAST = 3;
    localparam int CW_RAMP = 4;
    localparam int CW_USE_RAMP = 5;
    localparam int CW_START = 6;
    localparam int CW_RESET = 7;
    localparam int CW_JOG1 = 8;
    localparam int CW_JOG2 = 9;
    localparam int CW_VALID = 10;
    localparam int CW_SLOW = 11;
    localparam int CW_CATCH = 12;
    localparam int CW_SET_LO = 13;
    localparam int CW_SET_HI = 14;
    localparam int CW_REVERSE = 15;
    // Status word bit positions
    localparam int SW_CTRL_RDY = 0;
    localparam int SW_DRV_RDY = 1;
    localparam int SW_ENABLE = 2;
    localparam int SW_TRIP = 3;
    localparam int SW_ON2 = 4;
    localparam int SW_ON3 = 5;
    localparam int SW_NO_START = 6;
    localparam int SW_WARN = 7;
    localparam int SW_AT_REF = 8;
    localparam int SW_BUS_CTRL = 9;
    localparam int SW_FREQ_OK = 10;
    localparam int SW_RUNNING = 11;
    localparam int SW_TEMP_STOP = 12;
    localparam int SW_VOLT = 13;
    localparam int SW_TORQUE = 14;
    localparam int SW_TIMER = 15;
    // APB register byte offsets
    localparam logic [7:0] REG_COMMAND = 8'h00;
    localparam logic [7:0] REG_REFERENCE = 8'h04;
    localparam logic [7:0] REG_CONFIG = 8'h08;
    localparam logic [7:0] REG_TRIM = 8'h0C;
    localparam logic [7:0] REG_JOG = 8'h10;
    localparam logic [7:0] REG_STATUS = 8'h14;
    localparam logic [7:0] REG_ACTUAL = 8'h18;
    localparam logic [7:0] REG_ACTION = 8'h1C;
    localparam logic [7:0] REG_DRIVE = 8'h20;
    // Config register fields
    localparam int CF_MULTI = 0;
    localparam int CF_REV_LO = 1;
    localparam int CF_REV_HI = 2;
    localparam int CF_RELAY = 3;
    localparam int CF_LINK_LO = 4;
    localparam int CF_LINK_HI = 7;
    // Drive state input register fields
    localparam int DS_TRIPPED = 0;
    localparam int DS_POWER = 1;
    localparam int DS_RUNNING = 2;
    localparam int DS_WARN = 3;
    localparam int DS_AT_REF = 4;
    localparam int DS_BUS_CTRL = 5;
    localparam int DS_FREQ_OK = 6;
    localparam int DS_TEMP_STOP = 7;
    localparam int DS_VOLT = 8;
    localparam int DS_TORQUE = 9;
    localparam int DS_TIMER = 10;
    localparam int DS_ZERO_HZ = 11;
    // Reversing source selections
    localparam logic [1:0] REV_DIGITAL = 2'h0;
    localparam logic [1:0] REV_SERIAL = 2'h1;
    localparam logic [1:0] REV_OR = 2'h2;
    localparam logic [1:0] REV_AND = 2'h3;
    // Reference scaling: 100 percent
    localparam logic signed [15:0] REF_FULL = 16'sh4000;
    typedef enum logic [1:0] {FDC_STOP_NONE, FDC_STOP_RAMP, FDC_STOP_QUICK, FDC_STOP_COAST} fdc_stop_t;
endpackage

// file: fdc_core.sv
// Fieldbus command word decoder and status word builder with APB registers
//
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
module fdc_core (
    // APB
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Telegram from master
    input wire logic tel_valid,
    input wire logic [15:0] command_word,
    input wire logic signed [15:0] tel_reference,
    // Drive state inputs
    input wire logic drive_tripped,
    input wire logic power_supplied,
    input wire logic motor_running,
    input wire logic zero_hz,
    input wire logic signed [15:0] actual_frequency,
    // Telegram to master
    output logic [15:0] state_report_word,
    output logic signed [15:0] actual_frequency_word,
    // Decoded commands
    output fdc_pkg::fdc_stop_t stop_mode,
    output logic start_allowed,
    output logic hold_freq,
    output logic fault_reset,
    output logic jog1,
    output logic jog2,
    output logic signed [15:0] speed_reference,
    output logic [1:0] active_setup,
    output logic reverse,
    output logic stop_relay
);
    import fdc_pkg::*;

    logic [15:0] cw;
    logic signed [15:0] ref_in;
    logic cw_prev_reset;
    logic [7:0] cfg;
    logic signed [15:0] trim;
    logic signed [15:0] sw_ref;
    logic [11:0] sw_state;
    logic no_start;
    logic [1:0] pending_setup;
    logic sw_reg_wr;
    logic [15:0] cw_eff;
    logic tripped;
    logic [15:0] next_status;

    // Saturating signed add keeps trimmed reference in range
    function automatic logic signed [15:0] sat_add(input logic signed [15:0] a, input logic signed [15:0] b);
        logic signed [16:0] s;
        s = 17'(a) + 17'(b);
        if (s > 17'sh07FFF) begin
            sat_add = 16'sh7FFF;
        end else if (s < -17'sh08000) begin
            sat_add = -16'sh8000;
        end else begin
            sat_add = s[15:0];
        end
    endfunction

    function automatic logic cw_bit(input logic [15:0] w, input int pos);
        cw_bit = w[pos];
    endfunction

    assign sw_reg_wr = psel && penable && pwrite;
    assign tripped = drive_tripped || sw_state[DS_TRIPPED];

    // Command word and reference latched together; bit 10 low discards the word
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cw <= 16'h0000;
            ref_in <= 16'sh0000;
        end else if (tel_valid && command_word[CW_VALID]) begin
            cw <= command_word;
            ref_in <= tel_reference;
        end else if (sw_reg_wr && paddr == REG_COMMAND && pwdata[CW_VALID]) begin
            cw <= pwdata[15:0];
            ref_in <= sw_ref;
        end
    end

    // Software reference staging and configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sw_ref <= 16'sh0000;
            cfg <= 8'h00;
            trim <= 16'sh0000;
            sw_state <= 12'h000;
        end else if (sw_reg_wr) begin
            case (paddr)
                REG_REFERENCE: sw_ref <= pwdata[15:0];
                REG_CONFIG: cfg <= pwdata[7:0];
                REG_TRIM: trim <= pwdata[15:0];
                REG_DRIVE: sw_state <= pwdata[11:0];
                default: ;
            endcase
        end
    end

    assign cw_eff = cw;

    // Stop priority: coast, then quick, then ramp
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stop_mode <= FDC_STOP_COAST;
            start_allowed <= 1'b0;
            hold_freq <= 1'b0;
            stop_relay <= 1'b0;
        end else begin
            if (!cw_eff[CW_ON2] || !cw_eff[CW_NOCOAST]) begin
                stop_mode <= FDC_STOP_COAST;
            end else if (!cw_eff[CW_ON3]) begin
                stop_mode <= FDC_STOP_QUICK;
            end else if (!cw_eff[CW_RAMP] && !(cw_eff[CW_JOG1] || cw_eff[CW_JOG2])) begin
                stop_mode <= FDC_STOP_QUICK;
            end else if (!cw_eff[CW_ON1] || !cw_eff[CW_START]) begin
                stop_mode <= FDC_STOP_RAMP;
            end else begin
                stop_mode <= FDC_STOP_NONE;
            end
            start_allowed <= cw_eff[CW_ON1] && cw_eff[CW_ON2] && cw_eff[CW_ON3] && cw_eff[CW_NOCOAST]
                && cw_eff[CW_RAMP] && cw_eff[CW_START] && !tripped;
            hold_freq <= !cw_eff[CW_USE_RAMP];
            // Relay only when stop came from bits 00-02/06 and frequency is zero
            stop_relay <= cfg[CF_RELAY] && (zero_hz || sw_state[DS_ZERO_HZ])
                && (!cw_eff[CW_ON1] || !cw_eff[CW_ON2] || !cw_eff[CW_ON3] || !cw_eff[CW_START]);
        end
    end

    // Fault reset on rising edge of reset bit only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cw_prev_reset <= 1'b0;
            fault_reset <= 1'b0;
        end else begin
            cw_prev_reset <= cw_eff[CW_RESET];
            fault_reset <= cw_eff[CW_RESET] && !cw_prev_reset;
        end
    end

    // Jog, trim, reverse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            jog1 <= 1'b0;
            jog2 <= 1'b0;
            speed_reference <= 16'sh0000;
            reverse <= 1'b0;
        end else begin
            jog1 <= cw_eff[CW_JOG1] && !cw_eff[CW_RAMP] && (&cw_eff[CW_NOCOAST:CW_ON1]);
            jog2 <= cw_eff[CW_JOG2] && !cw_eff[CW_RAMP] && (&cw_eff[CW_NOCOAST:CW_ON1]);
            if (cw_bit(cw_eff, CW_SLOW)) begin
                speed_reference <= sat_add(ref_in, -trim);
            end else if (cw_bit(cw_eff, CW_CATCH)) begin
                speed_reference <= sat_add(ref_in, trim);
            end else begin
                speed_reference <= ref_in;
            end
            reverse <= cw_eff[CW_REVERSE] && cfg[CF_REV_HI:CF_REV_LO] != REV_DIGITAL;
        end
    end

    // Set-up selection; a running change is held back unless linked
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active_setup <= 2'h0;
            pending_setup <= 2'h0;
        end else if (cfg[CF_MULTI]) begin
            pending_setup <= cw_eff[CW_SET_HI:CW_SET_LO];
            if (!(motor_running || sw_state[DS_RUNNING])) begin
                active_setup <= pending_setup;
            end else if (cfg[CF_LINK_LO + 32'(active_setup)] && cfg[CF_LINK_LO + 32'(pending_setup)]) begin
                active_setup <= pending_setup;
            end
        end
    end

    // Start-not-possible flag: set wins over clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            no_start <= 1'b1;
        end else if (fault_reset || !cw_eff[CW_ON2] || !cw_eff[CW_ON3]) begin
            no_start <= 1'b1;
        end else if (!cw_eff[CW_ON1] && cw_eff[CW_VALID]) begin
            no_start <= 1'b0;
        end
    end

    // Status word assembly
    always_comb begin
        next_status = 16'h0000;
        next_status[SW_CTRL_RDY] = cw_eff[CW_ON1] && cw_eff[CW_ON2] && cw_eff[CW_ON3] && !tripped;
        next_status[SW_DRV_RDY] = next_status[SW_CTRL_RDY]
            && (power_supplied || sw_state[DS_POWER]);
        next_status[SW_ENABLE] = next_status[SW_CTRL_RDY];
        next_status[SW_TRIP] = tripped;
        next_status[SW_ON2] = cw_eff[CW_ON2];
        next_status[SW_ON3] = cw_eff[CW_ON3];
        next_status[SW_NO_START] = no_start;
        next_status[SW_WARN] = sw_state[DS_WARN];
        next_status[SW_AT_REF] = sw_state[DS_AT_REF];
        next_status[SW_BUS_CTRL] = sw_state[DS_BUS_CTRL];
        next_status[SW_FREQ_OK] = sw_state[DS_FREQ_OK];
        next_status[SW_RUNNING] = motor_running || sw_state[DS_RUNNING];
        next_status[SW_TEMP_STOP] = sw_state[DS_TEMP_STOP];
        next_status[SW_VOLT] = sw_state[DS_VOLT];
        next_status[SW_TORQUE] = sw_state[DS_TORQUE];
        next_status[SW_TIMER] = sw_state[DS_TIMER];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_report_word <= 16'h0000;
            actual_frequency_word <= 16'sh0000;
        end else begin
            state_report_word <= next_status;
            actual_frequency_word <= actual_frequency;
        end
    end

    // APB slave: zero wait states, error on unmapped address
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            if (psel && !penable) begin
                case (paddr)
                    REG_COMMAND: prdata <= {16'h0000, cw};
                    REG_REFERENCE: prdata <= {16'h0000, sw_ref};
                    REG_CONFIG: prdata <= {24'h000000, cfg};
                    REG_TRIM: prdata <= {16'h0000, trim};
                    REG_JOG: prdata <= {30'h0, jog2, jog1};
                    REG_STATUS: prdata <= {16'h0000, state_report_word};
                    REG_ACTUAL: prdata <= {16'h0000, actual_frequency_word};
                    REG_ACTION: prdata <= {16'h0000, speed_reference};
                    REG_DRIVE: prdata <= {20'h00000, sw_state};
                    default: pslverr <= 1'b1;
                endcase
            end
        end
    end
endmodule

// file: fdc_core_chk.sv
// Property checker for the drive command decoder
`timescale 1ns/1ps
module fdc_core_chk (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Inputs
    input wire logic psel,
    input wire logic tel_valid,
    input wire logic [15:0] command_word,
    input wire logic signed [15:0] actual_frequency,
    // Outputs
    input wire logic [15:0] state_report_word,
    input wire logic signed [15:0] actual_frequency_word,
    input wire fdc_pkg::fdc_stop_t stop_mode,
    input wire logic signed [15:0] speed_reference,
    input wire logic fault_reset,
    input wire logic jog1,
    input wire logic jog2
);
    import fdc_pkg::*;
    logic [15:0] lat_cw;
    logic take;
    logic rise;
    assign take = tel_valid && command_word[CW_VALID];
    assign rise = take && command_word[CW_RESET] && !lat_cw[CW_RESET];
    // Last accepted word; outputs lag it by up to three edges
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lat_cw <= 16'h0000;
        end else if (take) begin
            lat_cw <= command_word;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_take;
        take;
    endsequence
    sequence s_quiet;
        !take && !psel;
    endsequence
    a_mirror_bits: assert property (s_take |-> ##[1:3] state_report_word[5:4] == lat_cw[2:1])
        else $error("status mirror");
    a_ctrl_off: assert property ((s_take and !(&command_word[2:0])) |-> ##[1:3] !state_report_word[0])
        else $error("control ready");
    a_drive_ready: assert property (state_report_word[SW_DRV_RDY] |-> state_report_word[SW_CTRL_RDY])
        else $error("drive ready");
    a_start_block: assert property ((s_take and !(&command_word[2:1])) |-> ##[1:3] state_report_word[6])
        else $error("start flag");
    a_idle_hold: assert property (s_quiet[*4] |-> $stable(speed_reference) && $stable(stop_mode))
        else $error("idle change");
    a_reset_rise: assert property (rise |-> ##[1:3] fault_reset)
        else $error("reset missed");
    a_reset_cause: assert property (fault_reset |-> $past(rise) || $past(rise, 2) || $past(rise, 3))
        else $error("reset spurious");
    a_jog_gate: assert property ($rose(jog1) || $rose(jog2) |-> lat_cw[4:0] == 5'h0F)
        else $error("jog gate");
    a_freq_copy: assert property ($changed(actual_frequency) |=> actual_frequency_word == $past(actual_frequency))
        else $error("freq copy");
endmodule
bind fdc_core fdc_core_chk u_chk (.*);

// file: fdc_master.sv
// Fieldbus master model that sends command telegrams
`timescale 1ns/1ps
module fdc_master (
    // Clock
    input wire logic pclk,
    // Telegram
    output logic tel_valid,
    output logic [15:0] command_word,
    output logic signed [15:0] tel_reference
);
    initial begin
        tel_valid = 1'b0;
        command_word = 16'h0000;
        tel_reference = 16'sh0000;
    end
    task automatic send(input logic [15:0] cw, input logic signed [15:0] rf);
        tel_valid <= 1'b1;
        command_word <= cw;
        tel_reference <= rf;
        @(posedge pclk);
        tel_valid <= 1'b0;
        // Idle lines inverted so stale data never passes for live
        command_word <= ~cw;
        tel_reference <= ~rf;
    endtask
endmodule

// file: fdc_tb.sv
// Self-checking bench for the drive command decoder
`timescale 1ns/1ps
module testbench;
    import fdc_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, er, ns, tel_valid;
    logic [15:0] command_word, state_report_word;
    logic signed [15:0] tel_reference, actual_frequency_word, speed_reference;
    logic drive_tripped = 1'b0, power_supplied = 1'b1, motor_running = 1'b0, zero_hz = 1'b1;
    logic signed [15:0] actual_frequency = 16'sh0000;
    fdc_stop_t stop_mode;
    logic start_allowed, hold_freq, fault_reset, jog1, jog2, reverse, stop_relay;
    logic [1:0] active_setup;
    int n_fail = 0, cmp_count = 0, n_rst = 0;
    logic [7:0] cws [8] = '{8'h7F, 8'h7E, 8'h7D, 8'h7B, 8'h77, 8'h6F, 8'h5F, 8'h3F};
    fdc_stop_t mds [8] = '{FDC_STOP_NONE, FDC_STOP_RAMP, FDC_STOP_COAST, FDC_STOP_QUICK,
        FDC_STOP_COAST, FDC_STOP_QUICK, FDC_STOP_NONE, FDC_STOP_RAMP};
    fdc_master u_mst (.*);
    fdc_core u_dut (.*);
    always #10 pclk = ~pclk;
    always @(posedge pclk) begin
        if (fault_reset === 1'b1) begin
            n_rst <= n_rst + 1;
        end
    end
    task chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            n_fail++;
            $display("ERROR %0t got %h want %h", $time, s, e);
        end
    endtask
    task final_report;
        if (n_fail == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Request held until the edge that sees pready high
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            n_fail++;
            final_report;
        end else begin
            @(posedge pclk);
        end
    endtask
    // Margin over the up-to-three-edge latency
    task tg(input logic [15:0] cw, input logic [15:0] r);
        u_mst.send(cw, r);
        repeat (4) @(posedge pclk);
    endtask
    task tref(input logic [15:0] cw, input logic [15:0] r, input logic signed [15:0] e);
        tg(cw, r);
        chk(speed_reference, e);
    endtask
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        chk(state_report_word[SW_NO_START], 1'b1);
        apb(1'b1, REG_TRIM, 32'h00000100);
        apb(1'b1, REG_CONFIG, 32'h0000000B);
        apb(1'b0, REG_CONFIG, 32'h00000000);
        chk(rd, 32'h0000000B);
        apb(1'b0, 8'h24, 32'h00000000);
        chk(er, 1'b1);
        chk(rd, 32'h00000000);
        ns = 1'b1;
        for (int i = 0; i < 8; i++) begin
            tg({8'h04, cws[i]}, 16'h2000);
            ns = (!cws[i][1] || !cws[i][2]) ? 1'b1 : (cws[i][0] ? ns : 1'b0);
            chk(stop_mode, mds[i]);
            chk(hold_freq, !cws[i][5]);
            chk(start_allowed, &cws[i][4:0] && cws[i][6]);
            chk(stop_relay, !(&cws[i][2:0] && cws[i][6]));
            chk(state_report_word[6:0], {ns, cws[i][2:1], 1'b0, {3{&cws[i][2:0]}}});
        end
        tg(16'h00FF, 16'h1234);
        chk(stop_mode, FDC_STOP_RAMP);
        chk(speed_reference, 16'h2000);
        tg(16'h04FF, 16'h0000);
        tg(16'h04FF, 16'h0000);
        tg(16'h047F, 16'h0000);
        tg(16'h04FF, 16'h0000);
        chk(n_rst, 2);
        tg(16'h052F, 16'h0000);
        chk({jog2, jog1}, 2'b01);
        tg(16'h062F, 16'h0000);
        chk({jog2, jog1}, 2'b10);
        tg(16'h077F, 16'h0000);
        chk({jog2, jog1}, 2'b00);
        tref(16'h0C7F, 16'h2000, 16'h1F00);
        tref(16'h147F, 16'h2000, 16'h2100);
        tref(16'h1C7F, 16'h2000, 16'h1F00);
        tref(16'h147F, 16'h7FF0, 16'h7FFF);
        tref(16'h047F, -REF_FULL, 16'hC000);
        tg(16'h447F, 16'h0000);
        chk(active_setup, 2'h2);
        motor_running <= 1'b1;
        tg(16'h647F, 16'h0000);
        chk(active_setup, 2'h2);
        apb(1'b1, REG_CONFIG, 32'h000000CB);
        repeat (3) @(posedge pclk);
        chk(active_setup, 2'h3);
        motor_running <= 1'b0;
        for (int s = 0; s < 4; s++) begin
            apb(1'b1, REG_CONFIG, {28'h0000000, 1'b1, 2'(s), 1'b1});
            tg(16'h847F, 16'h0000);
            chk(reverse, s != 0);
        end
        drive_tripped <= 1'b1;
        tg(16'h047F, 16'h0000);
        chk(state_report_word[1:0], 2'b00);
        drive_tripped <= 1'b0;
        power_supplied <= 1'b0;
        tg(16'h047F, 16'h0000);
        chk(state_report_word[1:0], 2'b01);
        power_supplied <= 1'b1;
        actual_frequency <= 16'sh9ABC;
        tg(16'h047F, 16'h0000);
        apb(1'b0, REG_STATUS, 32'h00000000);
        chk(rd[1:0], 2'b11);
        apb(1'b0, REG_ACTUAL, 32'h00000000);
        chk(rd, 32'h00009ABC);
        chk(actual_frequency_word, 16'sh9ABC);
        final_report;
    end
endmodule
